// [core/tsec_cfg.svh]
/*
  Constants of the two-stage event controller: register offsets, reset values,
  event numbers and sizes. Assumes it is included once per compile unit.
*/
`ifndef TSEC_CFG_SVH
`define TSEC_CFG_SVH
`define TSEC_NSRC 32
`define TSEC_NEVT 16
`define TSEC_NGP 9
`define TSEC_GP_BASE 7
`define TSEC_OFS_LATCH 8'h00
`define TSEC_OFS_MASK 8'h04
`define TSEC_OFS_NEST 8'h08
`define TSEC_OFS_GLOBAL 8'h0c
`define TSEC_OFS_SRC_EN 8'h10
`define TSEC_OFS_SRC_ASSERT 8'h14
`define TSEC_OFS_WAKE_EN 8'h18
`define TSEC_OFS_ASSIGN0 8'h20
`define TSEC_OFS_ASSIGN3 8'h2c
`define TSEC_RST_MASK 16'h0000
`define TSEC_RST_SRC_EN 32'h0000_0000
`define TSEC_RST_WAKE_EN 32'h0000_0000
`define TSEC_NONMASK 16'h000f
`define TSEC_GP_BITS 16'hff80
`define TSEC_EVT_NONE 5'h10
`define TSEC_RESP_OKAY 2'h0
`define TSEC_RESP_SLVERR 2'h2
`endif

// [core/tsec_pkg.sv]
/*
  Types of the two-stage event controller.
  Assumes tsec_cfg.svh is on the include path.
*/
`include "tsec_cfg.svh"
package tsec_pkg;
  typedef logic [`TSEC_NEVT-1:0] tsec_evt_t;
  typedef logic [`TSEC_NSRC-1:0] tsec_src_t;
  typedef enum logic {TSEC_WR_IDLE, TSEC_WR_RESP} tsec_wr_state_t;
endpackage

// [core/tsec_top.sv]
/*
  Two-stage event controller: a routing stage maps 32 peripheral sources onto
  nine general-purpose core inputs, and a core stage latches, masks, nests and
  dispatches events. Registers sit behind an AXI4-Lite slave on aclk.
  Assumes peripheral and dedicated event pins are asynchronous to aclk, and
  that the processor drives its instruction strobes on aclk.
*/
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
// Functional notes
// - Nine general inputs, events 7 to 15.
// - Fixed priorities, zero highest, numeric order.
// - Programmable source assignment with reset defaults.
// - Latch, mask, nest registers, 16 bits each.
// - Latch set by edge, cleared on acceptance.
// - Mask bit set lets event be serviced.
// - Mask readable and writable only in supervisor.
// - Global enable and disable of general inputs.
// - Nest bit marks active event, hardware only.
// - Source enable, status, wakeup registers, 32 bits.
// - Source enable bit passes source to core.
// - Status bit shows source currently asserting.
// - Enabled source wakes idle or sleeping core.
// - Nest register serves as routing acknowledgement; the routing stage here never reads it.
// - Rising edge sets latch, two-cycle detection.
// - Latch clears when nest bit sets; requeue.
// - Nest bit at least three cycles after edge.
// - Nesting; higher priority always takes precedence.
module tsec_top
  import tsec_pkg::*;
#(
  parameter logic [`TSEC_NSRC*4-1:0] DEFAULT_ASSIGN = 128'h0654_3210_6543_2106_5432_1065_4321_0654
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`TSEC_NSRC-1:0] periph_irq,
  input wire logic emulation_entry,
  input wire logic nmi_in,
  input wire logic exception_entry,
  input wire logic hardware_error_entry,
  input wire logic core_timer_entry,
  input wire logic global_interrupt_on_instr,
  input wire logic global_interrupt_off_instr,
  input wire logic event_return,
  input wire logic core_idle,
  output logic event_taken,
  output logic [3:0] event_number,
  output logic [`TSEC_NEVT-1:0] core_event_active_nest,
  output logic wakeup_req
);

  // Lowest set bit index, or TSEC_EVT_NONE when empty.
  function automatic logic [4:0] lowest_evt(input tsec_evt_t v);
    logic [4:0] r;
    r = `TSEC_EVT_NONE;
    for (int i = `TSEC_NEVT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  tsec_evt_t core_event_latch_reg;
  tsec_evt_t core_event_latch_next;
  tsec_evt_t core_event_enable_mask_reg;
  tsec_evt_t nest_reg;
  tsec_evt_t nest_next;
  tsec_src_t peripheral_source_enable_reg;
  tsec_src_t peripheral_wakeup_enable_reg;
  logic [3:0] assign_reg [0:`TSEC_NSRC-1];
  logic global_on_reg;
  tsec_src_t src_sync1_reg;
  tsec_src_t src_sync2_reg;
  logic [4:0] ded_sync1_reg;
  logic [4:0] ded_sync2_reg;
  tsec_evt_t evt_prev_reg;
  tsec_evt_t evt_level;
  tsec_evt_t evt_rise;
  tsec_evt_t eligible;
  logic [`TSEC_NGP-1:0] gp_level;
  logic [4:0] best_req;
  logic [4:0] best_nest;
  logic dispatch;

  tsec_wr_state_t wr_state_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic aw_priv_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic wr_err;
  logic rd_err;
  logic [31:0] rd_val;

  // Peripheral and dedicated event pins pass two flip-flops before any logic looks at them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sync1_reg <= '0;
      src_sync2_reg <= '0;
      ded_sync1_reg <= '0;
      ded_sync2_reg <= '0;
    end else begin
      src_sync1_reg <= periph_irq;
      src_sync2_reg <= src_sync1_reg;
      ded_sync1_reg <= {core_timer_entry, hardware_error_entry, exception_entry,
                        nmi_in, emulation_entry};
      ded_sync2_reg <= ded_sync1_reg;
    end
  end

  // Shared sources are ORed per input; the edge detector re-arms on its own.
  always_comb begin
    gp_level = '0;
    for (int s = 0; s < `TSEC_NSRC; s++) begin
      if (peripheral_source_enable_reg[s] && src_sync2_reg[s] &&
          assign_reg[s] < 4'(`TSEC_NGP)) begin
        gp_level[assign_reg[s]] = 1'b1;
      end
    end
  end

  // Bits 1 and 4 stay zero: reset is the aresetn itself and 4 is reserved.
  assign evt_level = {gp_level, ded_sync2_reg[4:3], 1'b0, ded_sync2_reg[2:1], 1'b0,
                      ded_sync2_reg[0]};
  assign evt_rise = evt_level & ~evt_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_prev_reg <= '0;
    end else begin
      evt_prev_reg <= evt_level;
    end
  end

  always_comb begin
    eligible = core_event_latch_reg & (core_event_enable_mask_reg | `TSEC_NONMASK);
    if (!global_on_reg) begin
      eligible = eligible & ~`TSEC_GP_BITS;
    end
  end

  assign best_req = lowest_evt(eligible);
  assign best_nest = lowest_evt(nest_reg);
  assign dispatch = (best_req != `TSEC_EVT_NONE) && (best_req < best_nest);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_on_reg <= 1'b0;
    end else if (global_interrupt_on_instr) begin
      global_on_reg <= 1'b1;
    end else if (global_interrupt_off_instr) begin
      global_on_reg <= 1'b0;
    end
  end

  always_comb begin
    core_event_latch_next = core_event_latch_reg;
    if (wr_fire && !wr_err && aw_addr_reg == `TSEC_OFS_LATCH) begin
      core_event_latch_next = (core_event_latch_reg & core_event_enable_mask_reg) |
        (16'(merge_strb({16'h0000, core_event_latch_reg}, w_data_reg, w_strb_reg))
         & ~core_event_enable_mask_reg);
    end
    if (dispatch) begin
      core_event_latch_next[best_req[3:0]] = 1'b0;
    end
    core_event_latch_next = core_event_latch_next | evt_rise;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_event_latch_reg <= '0;
    end else begin
      core_event_latch_reg <= core_event_latch_next;
    end
  end

  always_comb begin
    nest_next = nest_reg;
    if (event_return && best_nest != `TSEC_EVT_NONE) begin
      nest_next[best_nest[3:0]] = 1'b0;
    end
    if (dispatch) begin
      nest_next[best_req[3:0]] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nest_reg <= '0;
      event_taken <= 1'b0;
      event_number <= 4'h0;
    end else begin
      nest_reg <= nest_next;
      event_taken <= dispatch;
      if (dispatch) begin
        event_number <= best_req[3:0];
      end
    end
  end

  assign core_event_active_nest = nest_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_req <= 1'b0;
    end else begin
      wakeup_req <= core_idle && |(src_sync2_reg & peripheral_wakeup_enable_reg);
    end
  end

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = !aw_got_reg && wr_state_reg == TSEC_WR_IDLE;
  assign s_axi_wready = !w_got_reg && wr_state_reg == TSEC_WR_IDLE;
  assign wr_fire = aw_got_reg && w_got_reg && wr_state_reg == TSEC_WR_IDLE;

  // Core-stage registers refuse unprivileged access.
  always_comb begin
    wr_err = 1'b0;
    case (aw_addr_reg)
      `TSEC_OFS_LATCH, `TSEC_OFS_MASK: wr_err = !aw_priv_reg;
      `TSEC_OFS_SRC_EN, `TSEC_OFS_WAKE_EN: wr_err = 1'b0;
      default: wr_err = !(aw_addr_reg >= `TSEC_OFS_ASSIGN0 &&
                          aw_addr_reg <= `TSEC_OFS_ASSIGN3 && aw_addr_reg[1:0] == 2'h0);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      aw_priv_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
      aw_priv_reg <= s_axi_awprot[0];
    end else if (wr_fire) begin
      aw_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= TSEC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSEC_RESP_OKAY;
    end else begin
      case (wr_state_reg)
        TSEC_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= TSEC_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `TSEC_RESP_SLVERR : `TSEC_RESP_OKAY;
          end
        end
        TSEC_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= TSEC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state_reg <= TSEC_WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_event_enable_mask_reg <= `TSEC_RST_MASK;
    end else if (wr_fire && !wr_err && aw_addr_reg == `TSEC_OFS_MASK) begin
      core_event_enable_mask_reg <= 16'(merge_strb({16'h0000, core_event_enable_mask_reg},
                                                   w_data_reg, w_strb_reg));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peripheral_source_enable_reg <= `TSEC_RST_SRC_EN;
      peripheral_wakeup_enable_reg <= `TSEC_RST_WAKE_EN;
    end else if (wr_fire && !wr_err) begin
      if (aw_addr_reg == `TSEC_OFS_SRC_EN) begin
        peripheral_source_enable_reg <= merge_strb(peripheral_source_enable_reg,
                                                   w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == `TSEC_OFS_WAKE_EN) begin
        peripheral_wakeup_enable_reg <= merge_strb(peripheral_wakeup_enable_reg,
                                                   w_data_reg, w_strb_reg);
      end
    end
  end

  // Each assignment word holds eight 4-bit fields; values 9 to 15 route nowhere.
  generate
    for (genvar s = 0; s < `TSEC_NSRC; s++) begin : g_assign
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          assign_reg[s] <= DEFAULT_ASSIGN[s*4 +: 4];
        end else if (wr_fire && !wr_err && aw_addr_reg == `TSEC_OFS_ASSIGN0 + 8'(s / 8 * 4)
                     && w_strb_reg[(s % 8) / 2]) begin
          assign_reg[s] <= w_data_reg[(s % 8) * 4 +: 4];
        end
      end
    end
  endgenerate

  // Read channel: one word answered the cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `TSEC_OFS_LATCH: rd_val = {16'h0000, core_event_latch_reg};
      `TSEC_OFS_MASK: rd_val = {16'h0000, core_event_enable_mask_reg};
      `TSEC_OFS_NEST: rd_val = {16'h0000, nest_reg};
      `TSEC_OFS_GLOBAL: rd_val = {31'h0000_0000, global_on_reg};
      `TSEC_OFS_SRC_EN: rd_val = peripheral_source_enable_reg;
      `TSEC_OFS_SRC_ASSERT: rd_val = src_sync2_reg;
      `TSEC_OFS_WAKE_EN: rd_val = peripheral_wakeup_enable_reg;
      default: begin
        if (s_axi_araddr >= `TSEC_OFS_ASSIGN0 && s_axi_araddr <= `TSEC_OFS_ASSIGN3 &&
            s_axi_araddr[1:0] == 2'h0) begin
          for (int k = 0; k < 8; k++) begin
            rd_val[k*4 +: 4] = assign_reg[{s_axi_araddr[3:2], 3'(k)}];
          end
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
    if (s_axi_araddr <= `TSEC_OFS_NEST && !s_axi_arprot[0]) begin
      rd_err = 1'b1;
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TSEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_err ? `TSEC_RESP_SLVERR : `TSEC_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [dv/tsec_props.sv]
/*
  Port assertions for the two-stage event controller.
  Assumes it is bound onto tsec_top, with aclk and the active-low synchronous aresetn.
*/
module tsec_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic nmi_in,
  input wire logic event_return,
  input wire logic core_idle,
  input wire logic event_taken,
  input wire logic [3:0] event_number,
  input wire logic [15:0] core_event_active_nest,
  input wire logic wakeup_req
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_taken_marks_nest: assert property (event_taken |-> core_event_active_nest[event_number])
    else $error("taken event not marked active");
  a_nest_needs_take: assert property ((core_event_active_nest & ~$past(core_event_active_nest))
    != 16'h0000 |-> event_taken && (core_event_active_nest & ~$past(core_event_active_nest))
    == (16'h0001 << event_number))
    else $error("active bit set without matching dispatch");
  a_dispatch_outranks: assert property (event_taken && !$past(event_return) |->
    ($past(core_event_active_nest) & ((16'h0002 << event_number) - 16'h0001)) == 16'h0000)
    else $error("dispatch did not outrank active events");
  a_return_clears_top: assert property (event_return && core_event_active_nest != 16'h0000 |=>
    (core_event_active_nest & $past(core_event_active_nest & (~core_event_active_nest + 16'h0001)))
    == 16'h0000)
    else $error("return left top active bit set");
  a_min_latency: assert property ($rose(nmi_in) && !core_event_active_nest[2] |=>
    !core_event_active_nest[2] [*2])
    else $error("event active too soon after edge");
  a_nmi_served: assert property ($rose(nmi_in) && (core_event_active_nest & 16'h0007) == 16'h0000
    |-> ##[3:12] core_event_active_nest[2])
    else $error("nonmaskable event not served");
  a_wake_when_idle: assert property (wakeup_req |-> $past(core_idle))
    else $error("wakeup without idle core");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule
bind tsec_top tsec_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .nmi_in(nmi_in), .event_return(event_return),
  .core_idle(core_idle), .event_taken(event_taken), .event_number(event_number),
  .core_event_active_nest(core_event_active_nest), .wakeup_req(wakeup_req));

// [dv/tsec_core_model.sv]
/*
  Processor core model: serves each dispatched event for eight cycles, then returns.
  Assumes hold comes from the bench on aclk; while hold is high no routine returns.
*/
module tsec_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold,
  input wire logic event_taken,
  input wire logic [15:0] nest,
  output logic event_return
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_reg;
  // A fresh dispatch restarts the count, so a nested routine ends before the one it interrupted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 8'h00;
      event_return <= 1'b0;
    end else begin
      event_return <= 1'b0;
      if (event_taken) begin
        cnt_reg <= 8'h08;
      end else if (cnt_reg > 8'h01) begin
        cnt_reg <= cnt_reg - 8'h01;
      end else if (cnt_reg == 8'h01) begin
        if (!hold) begin
          event_return <= 1'b1;
          cnt_reg <= 8'h00;
        end
      end else if (nest != 16'h0000 && !event_return) begin
        cnt_reg <= 8'h08;
      end
    end
  end
endmodule

// [dv/tb_two_stage_event_controller.sv]
/*
  Self-checking bench for the two-stage event controller.
  Assumes tsec_cfg.svh on the include path and the core model beside the design.
*/
`include "tsec_cfg.svh"
module tb_two_stage_event_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, hold = 1'b1, got;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0, periph_irq = 32'h0, rd, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic nmi_in = 1'b0, on_i = 1'b0, off_i = 1'b0, core_idle = 1'b0, emulation_entry = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, event_taken, event_return, wakeup_req;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] event_number, num;
  logic [15:0] nest, nz;
  int mismatches = 0, checked = 0;
  always #50 aclk = ~aclk;
  tsec_top uut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_irq,
    .emulation_entry, .nmi_in, .exception_entry(1'b0), .hardware_error_entry(1'b0),
    .core_timer_entry(1'b0), .global_interrupt_on_instr(on_i),
    .global_interrupt_off_instr(off_i), .event_return, .core_idle, .event_taken,
    .event_number, .core_event_active_nest(nest), .wakeup_req);
  tsec_core_model core (.aclk, .aresetn, .hold, .event_taken, .nest, .event_return);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Handshakes are judged at the falling edge, where they equal what the next rising edge samples.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [2:0] p);
    logic ha, hw, hr;
    @(posedge aclk);
    if (w) begin
      awaddr <= a; awprot <= p; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    end else begin
      araddr <= a; arprot <= p; arvalid <= 1'b1; rready <= 1'b1;
    end
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      ha = w ? awvalid && awready : arvalid && arready;
      hw = wvalid && wready;
      hr = w ? bvalid && bready : rvalid && rready;
      rd = rdata;
      rs = w ? bresp : rresp;
      @(posedge aclk);
      if (ha) begin
        awvalid <= 1'b0; arvalid <= 1'b0;
      end
      if (hw) wvalid <= 1'b0;
      if (hr) begin
        bready <= 1'b0; rready <= 1'b0;
      end
    end
  endtask
  task automatic take(input int lim);
    got = 1'b0;
    repeat (lim) begin
      @(negedge aclk);
      if (event_taken === 1'b1 && !got) begin
        got = 1'b1; num = event_number; nz = nest;
      end
    end
    @(posedge aclk);
  endtask
  task automatic t_regs;
    xfer(1'b0, `TSEC_OFS_MASK, 32'h0, 3'h1);
    chk(rd, 32'h0);
    xfer(1'b0, `TSEC_OFS_MASK, 32'h0, 3'h0);
    chk(rs, `TSEC_RESP_SLVERR);
    xfer(1'b1, `TSEC_OFS_NEST, 32'hffff, 3'h1);
    chk(rs, `TSEC_RESP_SLVERR);
    xfer(1'b0, 8'h40, 32'h0, 3'h1);
    chk(rs, `TSEC_RESP_SLVERR);
    xfer(1'b0, `TSEC_OFS_WAKE_EN, 32'h0, 3'h1);
    chk(rd, `TSEC_RST_WAKE_EN);
  endtask
  task automatic t_latch;
    xfer(1'b1, `TSEC_OFS_MASK, 32'h0280, 3'h1);
    chk(rs, `TSEC_RESP_OKAY);
    xfer(1'b1, `TSEC_OFS_MASK, 32'hffff, 3'h0);
    chk(rs, `TSEC_RESP_SLVERR);
    xfer(1'b0, `TSEC_OFS_MASK, 32'h0, 3'h1);
    chk(rd, 32'h0280);
    xfer(1'b1, `TSEC_OFS_LATCH, 32'h0380, 3'h1);
    xfer(1'b0, `TSEC_OFS_LATCH, 32'h0, 3'h1);
    chk(rd, 32'h0100);
    xfer(1'b1, `TSEC_OFS_LATCH, 32'h0, 3'h1);
  endtask
  task automatic t_route;
    // Source 0 goes to event 9; the two lowest inputs stay free for software.
    xfer(1'b1, `TSEC_OFS_ASSIGN0, 32'h0000_0002, 3'h1);
    on_i <= 1'b1;
    @(posedge aclk) on_i <= 1'b0;
    periph_irq[0] <= 1'b1;
    take(10);
    chk(got, 32'h0);
    xfer(1'b0, `TSEC_OFS_SRC_ASSERT, 32'h0, 3'h1);
    chk(rd, 32'h1);
    periph_irq[0] <= 1'b0;
    xfer(1'b1, `TSEC_OFS_SRC_EN, 32'h1, 3'h1);
    periph_irq[0] <= 1'b1;
    take(12);
    chk({got, num}, 32'h19);
    nmi_in <= 1'b1;
    take(12);
    chk({got, num}, 32'h12);
    chk(nz, 32'h0204);
    hold <= 1'b0;
    nmi_in <= 1'b0;
    repeat (4) @(negedge aclk);
    chk(nest, 32'h0200);
    repeat (12) @(negedge aclk);
    chk(nest, 32'h0);
    @(posedge aclk) periph_irq[0] <= 1'b0;
  endtask
  task automatic t_global;
    off_i <= 1'b1;
    @(posedge aclk) off_i <= 1'b0;
    repeat (3) @(posedge aclk);
    periph_irq[0] <= 1'b1;
    take(10);
    chk(got, 32'h0);
    xfer(1'b0, `TSEC_OFS_LATCH, 32'h0, 3'h1);
    chk(rd, 32'h0200);
    on_i <= 1'b1;
    @(posedge aclk) on_i <= 1'b0;
    take(10);
    chk({got, num}, 32'h19);
    xfer(1'b0, `TSEC_OFS_LATCH, 32'h0, 3'h1);
    chk(rd, 32'h0);
    periph_irq[0] <= 1'b0;
  endtask
  task automatic t_wake;
    xfer(1'b1, `TSEC_OFS_WAKE_EN, 32'h2, 3'h1);
    core_idle <= 1'b1;
    periph_irq[1] <= 1'b1;
    repeat (6) @(negedge aclk);
    chk(wakeup_req, 32'h1);
    @(posedge aclk) core_idle <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(wakeup_req, 32'h0);
    @(posedge aclk) periph_irq[1] <= 1'b0;
  endtask
  task automatic t_emu;
    emulation_entry <= 1'b1;
    take(12);
    chk({got, num}, 32'h10);
    chk(nz, 32'h0001);
    emulation_entry <= 1'b0;
    repeat (12) @(negedge aclk);
    chk(nest, 32'h0);
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_latch();
    t_route();
    t_global();
    t_wake();
    t_emu();
    end_of_test();
  end
endmodule
